// *** rtl/osd_device_end.sv ***
`default_nettype none
// Function
// R01 - glyph row byte tag 100, row low four
// R02 - column tag 00x single, 01x auto
// R03 - attribute row byte tag 101
// R04 - every byte is row, column or data
// R05 - host pads glyph rows with two fillers
// R06 - host pads attribute rows with one filler
// R07 - never leave auto format in transmission
// R08 - 15 by 30 glyph code store
// R09 - row attribute at column 30
// R10 - row 15 holds 28 control registers
// R11 - tall rows push later rows down
// R12 - wide rows show even columns only
// R13 - background bits 6-4, zero transparent
// R14 - bit 3 blinks, frame counted
// R15 - bits 2-0 glyph colour red green blue
// R16 - row intensity drives intensity high
// R17 - row bits tall and wide
// R18 - window one enable bit
// R19 - window one intensity, resets to one
// R20 - window one shadow sizes from row 15
// R21 - auto format advances column then row
// R22 - format b keeps row until new row
// R23 - filler writes are dropped harmlessly
module osd_device_end (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    osd_link_if.device link,
    input wire logic frame_tick,
    input wire logic [3:0] rd_row,
    input wire logic [4:0] rd_col,
    input wire logic rd_attr,
    input wire logic [3:0] scan_row,
    input wire logic in_window,
    input wire logic in_shadow,
    output logic [7:0] rd_data,
    output logic [2:0] pix_fg,
    output logic [2:0] pix_bg,
    output logic pix_blank,
    output logic [4:0] mem_col,
    output logic [3:0] mem_row,
    output logic pix_int,
    output logic win_on,
    output logic win_black,
    output logic [7:0] shadow_m,
    output logic [7:0] shadow_n,
    output logic [1:0] fmt
);
    typedef enum logic [1:0] {
        EXP_ROW,
        EXP_COL,
        EXP_DATA,
        EXP_NEXT
    } phase_t;

    // glyph store and attribute store
    logic [7:0] glyph_mem [0:14][0:29]; // R08
    logic [7:0] cattr_mem [0:14][0:29];
    logic [7:0] rattr_mem [0:14]; // R09
    logic [7:0] ctrl_mem [0:27]; // R10

    phase_t ph_ff, nxt_ph;
    osd_pkg::fmt_t fmt_ff, nxt_fmt;
    logic area_ff, nxt_area;
    logic [3:0] row_ff, nxt_row;
    logic [4:0] col_ff, nxt_col;
    logic wr_en;
    logic [7:0] b;

    // ****************************************************************
    // byte decoder
    // ****************************************************************
    function automatic logic is_row_byte(input logic [7:0] v);
        is_row_byte = v[7:osd_pkg::ROW_TAG_LSB] == osd_pkg::ROW_GLYPH_TAG ||
            v[7:osd_pkg::ROW_TAG_LSB] == osd_pkg::ROW_ATTR_TAG;
    endfunction

    // classify each byte by the phase; auto format is sticky since the
    // host may not leave it within one transmission
    always_comb begin
        b = link.data;
        nxt_ph = ph_ff;
        nxt_fmt = fmt_ff;
        nxt_area = area_ff;
        nxt_row = row_ff;
        nxt_col = col_ff;
        wr_en = 1'b0;
        if (!link.frame) begin
            nxt_ph = EXP_ROW;
            nxt_fmt = osd_pkg::FMT_A;
        end else if (link.valid) begin // R04
            unique case (ph_ff)
                EXP_ROW: begin
                    if (is_row_byte(b)) begin // R01 R03
                        nxt_area = b[osd_pkg::ROW_TAG_LSB];
                        nxt_row = b[3:0];
                        nxt_ph = EXP_COL;
                    end
                end
                // after data a row byte means a, a single column byte means b
                EXP_COL, EXP_NEXT: begin
                    if (is_row_byte(b)) begin // R22
                        nxt_area = b[osd_pkg::ROW_TAG_LSB];
                        nxt_row = b[3:0];
                        nxt_ph = EXP_COL;
                        if (ph_ff == EXP_NEXT) begin
                            nxt_fmt = osd_pkg::FMT_A;
                        end
                    end else begin
                        nxt_col = b[4:0]; // R02
                        nxt_ph = EXP_DATA;
                        if (b[7:osd_pkg::COL_TAG_LSB] ==
                            osd_pkg::COL_AUTO_TAG) begin
                            nxt_fmt = osd_pkg::FMT_C;
                        end else if (ph_ff == EXP_NEXT) begin
                            nxt_fmt = osd_pkg::FMT_B;
                        end
                    end
                end
                EXP_DATA: begin
                    wr_en = 1'b1;
                    if (fmt_ff == osd_pkg::FMT_C) begin // R07
                        nxt_col = col_ff + 5'h01; // R21
                        if (col_ff == osd_pkg::LAST_COL) begin
                            nxt_row = row_ff + 4'h1;
                        end
                    end else begin
                        nxt_ph = EXP_NEXT; // R22
                    end
                end
            endcase
        end
    end

    // format a versus b: after the first data, a row byte means a
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ph_ff <= EXP_ROW;
            fmt_ff <= osd_pkg::FMT_A;
            area_ff <= 1'b0;
            row_ff <= 4'h0;
            col_ff <= 5'h00;
        end else if (clk_en) begin
            ph_ff <= nxt_ph;
            area_ff <= nxt_area;
            row_ff <= nxt_row;
            col_ff <= nxt_col;
            fmt_ff <= nxt_fmt;
        end
    end

    // ****************************************************************
    // memory writes
    // ****************************************************************
    // out-of-range rows and columns 30/31 fall through untouched
    always_ff @(posedge clk_sys) begin
        if (clk_en && wr_en) begin
            if (row_ff < osd_pkg::NUM_ROWS && col_ff < osd_pkg::NUM_COLS) begin
                if (area_ff) begin
                    cattr_mem[row_ff][col_ff] <= b;
                end else begin
                    glyph_mem[row_ff][col_ff] <= b;
                end
            end
        end // R23
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 15; i++) begin
                rattr_mem[i] <= osd_pkg::CTRL_RESET;
            end
            for (int i = 0; i < 28; i++) begin
                ctrl_mem[i] <= (i == 1) ? osd_pkg::WIN1_CTRL_RESET
                    : osd_pkg::CTRL_RESET; // R19
            end
        end else if (clk_en && wr_en && area_ff) begin
            if (row_ff < osd_pkg::NUM_ROWS &&
                col_ff == osd_pkg::ROW_ATTR_COL) begin
                rattr_mem[row_ff] <= b; // R09
            end else if (row_ff == osd_pkg::CTRL_ROW &&
                col_ff < osd_pkg::NUM_CTRL_COLS) begin
                ctrl_mem[col_ff] <= b; // R10
            end
        end
    end

    // ****************************************************************
    // display lookup
    // ****************************************************************
    logic [5:0] blink_cnt_ff, nxt_blink_cnt;
    logic blink_ph_ff, nxt_blink_ph;
    logic [3:0] mrow;
    logic [4:0] srow; // 15 tall rows span 30 screen rows
    logic [4:0] mcol;
    logic [7:0] ra, ca, gc, w1;
    logic [7:0] nxt_rd;

    // screen row to memory row: each earlier tall row eats one extra
    always_comb begin
        srow = 5'h00;
        mrow = 4'h0;
        for (int i = 0; i < 15; i++) begin
            if (srow <= {1'b0, scan_row}) begin
                mrow = i[3:0];
            end
            srow = srow + (rattr_mem[i][osd_pkg::ROW_TALL_BIT] ? 5'h02 : 5'h01);
        end // R11 R17
    end

    always_comb begin
        ra = rattr_mem[mrow];
        mcol = ra[osd_pkg::ROW_WIDE_BIT] ? {rd_col[4:1], 1'b0} : rd_col; // R12
        ca = cattr_mem[mrow][mcol];
        gc = glyph_mem[mrow][mcol];
        w1 = ctrl_mem[osd_pkg::WIN1_CTRL_COL];
        if (rd_attr) begin
            nxt_rd = rd_row == osd_pkg::CTRL_ROW ? ctrl_mem[rd_col] :
                (rd_col == osd_pkg::ROW_ATTR_COL ? rattr_mem[rd_row]
                : cattr_mem[rd_row][rd_col]);
        end else begin
            nxt_rd = glyph_mem[rd_row][rd_col];
        end
        nxt_blink_cnt = blink_cnt_ff;
        nxt_blink_ph = blink_ph_ff;
        if (frame_tick) begin // R14
            if (blink_cnt_ff == osd_pkg::BLINK_HALF_FRAMES - 6'h01) begin
                nxt_blink_cnt = 6'h00;
                nxt_blink_ph = !blink_ph_ff;
            end else begin
                nxt_blink_cnt = blink_cnt_ff + 6'h01;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            blink_cnt_ff <= 6'h00;
            blink_ph_ff <= 1'b0;
            rd_data <= 8'h00;
            pix_fg <= 3'h0;
            pix_bg <= 3'h0;
            pix_blank <= 1'b1;
            mem_col <= 5'h00;
            mem_row <= 4'h0;
            pix_int <= 1'b0;
            win_on <= 1'b0;
            win_black <= 1'b0;
            shadow_m <= 8'h00;
            shadow_n <= 8'h00;
            fmt <= 2'h0;
        end else if (clk_en) begin
            blink_cnt_ff <= nxt_blink_cnt;
            blink_ph_ff <= nxt_blink_ph;
            rd_data <= (rd_col < osd_pkg::NUM_COLS || rd_attr) ? nxt_rd
                : 8'h00;
            pix_fg <= ca[2:0]; // R15
            pix_bg <= ca[osd_pkg::BG_MSB:osd_pkg::BG_LSB]; // R13
            pix_blank <= ca[osd_pkg::BLINK_BIT] && blink_ph_ff; // R14
            mem_col <= mcol;
            mem_row <= mrow;
            win_on <= w1[osd_pkg::WIN_EN_BIT] && in_window; // R18
            win_black <= w1[osd_pkg::WIN_EN_BIT] &&
                w1[osd_pkg::WIN_SHD_BIT] && in_shadow; // R20
            shadow_m <= ctrl_mem[osd_pkg::SHADOW_W_COL]; // R20
            shadow_n <= ctrl_mem[osd_pkg::SHADOW_H_COL];
            if (w1[osd_pkg::WIN_EN_BIT] && in_window) begin
                pix_int <= w1[osd_pkg::WIN_INT_BIT]; // R19
            end else begin
                pix_int <= ra[osd_pkg::ROW_INT_BIT]; // R16
            end
            fmt <= fmt_ff;
        end
    end

    assign link.ready = 1'b1;
    // gc only feeds unused_ok; the font stage gets mem_row and mem_col instead
    logic unused_ok;
    assign unused_ok = ^gc;
endmodule // osd_device_end
`default_nettype wire

// *** common/osd_pkg.sv ***
`default_nettype none
package osd_pkg;
    // ****************************************************************
    // byte classes and address fields
    // ****************************************************************
    localparam logic [2:0] ROW_GLYPH_TAG = 3'h4;
    localparam logic [2:0] ROW_ATTR_TAG = 3'h5;
    localparam logic [1:0] COL_SINGLE_TAG = 2'h0;
    localparam logic [1:0] COL_AUTO_TAG = 2'h1;
    localparam int ROW_TAG_LSB = 5;
    localparam int COL_TAG_LSB = 6;
    // ****************************************************************
    // memory geometry
    // ****************************************************************
    localparam logic [3:0] NUM_ROWS = 4'hf;
    localparam logic [4:0] NUM_COLS = 5'h1e;
    localparam logic [4:0] LAST_COL = 5'h1f;
    localparam logic [3:0] CTRL_ROW = 4'hf;
    localparam logic [4:0] ROW_ATTR_COL = 5'h1e;
    localparam logic [4:0] NUM_CTRL_COLS = 5'h1c;
    localparam logic [4:0] WIN1_CTRL_COL = 5'h01;
    localparam logic [4:0] SHADOW_W_COL = 5'h10;
    localparam logic [4:0] SHADOW_H_COL = 5'h11;
    // ****************************************************************
    // field positions and reset values
    // ****************************************************************
    localparam int BG_MSB = 6;
    localparam int BG_LSB = 4;
    localparam int BLINK_BIT = 3;
    localparam int ROW_INT_BIT = 2;
    localparam int ROW_TALL_BIT = 1;
    localparam int ROW_WIDE_BIT = 0;
    localparam int WIN_EN_BIT = 2;
    localparam int WIN_INT_BIT = 1;
    localparam int WIN_SHD_BIT = 0;
    localparam logic [7:0] WIN1_CTRL_RESET = 8'h02;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // blink half period in frames: 40 frames at 80 Hz gives about 1 Hz
    localparam logic [5:0] BLINK_HALF_FRAMES = 6'h28;
    // ****************************************************************
    // device user-side status
    // ****************************************************************
    typedef enum logic [1:0] {
        FMT_A,
        FMT_B,
        FMT_C
    } fmt_t;
endpackage
`default_nettype wire

// *** common/osd_link_if.sv ***
`default_nettype none
interface osd_link_if;
    logic [7:0] data;
    logic valid;
    logic ready;
    logic frame;
    modport host (output data, output valid, output frame, input ready);
    modport device (input data, input valid, input frame, output ready);
endinterface
`default_nettype wire

// *** rtl/osd_host_end.sv ***
`default_nettype none
// host end: takes bytes over APB and pushes them onto the link
module osd_host_end (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    osd_link_if.host link
);
    // offsets: 0x0 byte to send, 0x4 control (bit0 frame), 0x8 status
    localparam logic [11:0] OFS_TX = 12'h000;
    localparam logic [11:0] OFS_CTRL = 12'h004;
    localparam logic [11:0] OFS_STAT = 12'h008;

    logic [7:0] data_ff, nxt_data;
    logic valid_ff, nxt_valid;
    logic frame_ff, nxt_frame;
    logic [31:0] rd_ff, nxt_rd;
    logic rdy_ff, nxt_rdy;
    logic err_ff, nxt_err;
    logic access;

    // ****************************************************************
    // apb slave and link driver
    // ****************************************************************
    // a write to tx while a byte is pending stalls pready; this is the
    // host's back-pressure, so format c filler ordering stays with software
    always_comb begin
        access = psel && penable && !rdy_ff;
        nxt_data = data_ff;
        nxt_valid = valid_ff && !link.ready;
        nxt_frame = frame_ff;
        nxt_rd = rd_ff;
        nxt_rdy = 1'b0;
        nxt_err = 1'b0;
        if (access) begin
            unique case (paddr)
                OFS_TX: begin
                    if (!pwrite) begin
                        nxt_rdy = 1'b1;
                        nxt_rd = {24'h000000, data_ff};
                    end else if (!nxt_valid) begin
                        nxt_data = pwdata[7:0];
                        nxt_valid = 1'b1;
                        nxt_rdy = 1'b1;
                    end
                end
                OFS_CTRL: begin
                    nxt_rdy = 1'b1;
                    if (pwrite) begin
                        nxt_frame = pwdata[0];
                    end
                    nxt_rd = {31'h00000000, frame_ff};
                end
                OFS_STAT: begin
                    nxt_rdy = 1'b1;
                    nxt_rd = {31'h00000000, valid_ff};
                end
                default: begin
                    nxt_rdy = 1'b1;
                    nxt_err = 1'b1;
                    nxt_rd = 32'h00000000;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            data_ff <= 8'h00;
            valid_ff <= 1'b0;
            frame_ff <= 1'b0;
            rd_ff <= 32'h00000000;
            rdy_ff <= 1'b0;
            err_ff <= 1'b0;
        end else if (clk_en) begin
            data_ff <= nxt_data;
            valid_ff <= nxt_valid;
            frame_ff <= nxt_frame;
            rd_ff <= nxt_rd;
            rdy_ff <= nxt_rdy;
            err_ff <= nxt_err;
        end
    end

    assign link.data = data_ff;
    assign link.valid = valid_ff;
    assign link.frame = frame_ff;
    assign prdata = rd_ff;
    assign pready = rdy_ff;
    assign pslverr = err_ff;
endmodule // osd_host_end
`default_nettype wire

// *** tb/osd_link_checker.sv ***
`default_nettype none
module osd_link_checker (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [7:0] data,
    input wire logic valid,
    input wire logic ready,
    input wire logic frame,
    input wire logic [1:0] fmt
);
    // ************************************************************
    // class of last taken byte: 0 none, 1 row, 2 column, 3 data
    // ************************************************************
    logic [1:0] last_ff;
    logic [1:0] nxt_last;
    logic take;
    assign take = valid && frame && ready;
    // row tags are 10x, so a second row byte simply replaces the row
    always_comb begin
        nxt_last = last_ff;
        if (!frame) begin
            nxt_last = 2'h0;
        end else if (take) begin
            case (last_ff)
                2'h0: nxt_last = 2'h1;
                2'h1: nxt_last = (data[7:6] == 2'h2) ? 2'h1 : 2'h2;
                2'h2: nxt_last = 2'h3;
                default: nxt_last = (fmt == osd_pkg::FMT_C) ? 2'h3 :
                    (data[7] ? 2'h1 : 2'h2);
            endcase
        end
    end
    // register the class
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            last_ff <= 2'h0;
        end else begin
            last_ff <= nxt_last;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence s_auto_col;
        take && last_ff == 2'h1 && data[7:6] == 2'h1;
    endsequence
    sequence s_single_col;
        take && last_ff == 2'h1 && data[7:6] == 2'h0;
    endsequence
    sequence s_col_again;
        take && last_ff == 2'h3 && fmt != osd_pkg::FMT_C
            && data[7:6] == 2'h0;
    endsequence
    sequence s_row_again;
        take && last_ff == 2'h3 && fmt != osd_pkg::FMT_C
            && data[7:6] == 2'h2;
    endsequence
    property p_auto_enters_c;
        s_auto_col |-> ##[1:2] fmt == osd_pkg::FMT_C;
    endproperty
    property p_single_not_c;
        s_single_col |-> ##[1:2] fmt != osd_pkg::FMT_C;
    endproperty
    property p_col_gives_b;
        s_col_again |-> ##[1:2] fmt == osd_pkg::FMT_B;
    endproperty
    property p_row_gives_a;
        s_row_again |-> ##[1:2] fmt == osd_pkg::FMT_A;
    endproperty
    property p_c_sticks;
        fmt == osd_pkg::FMT_C && frame ##1 frame |-> fmt == osd_pkg::FMT_C;
    endproperty
    property p_idle_resets;
        !frame ##1 !frame |=> fmt == osd_pkg::FMT_A;
    endproperty
    property p_always_ready;
        1'b1 |-> ready;
    endproperty
    property p_valid_pulse;
        valid |=> !valid;
    endproperty
    property p_fmt_cause;
        $changed(fmt) |-> $past(take, 2) || !$past(frame, 2);
    endproperty
    a_auto_enters_c: assert property (p_auto_enters_c)
        else $error("auto column byte did not select format c");
    a_single_not_c: assert property (p_single_not_c)
        else $error("single column byte selected format c");
    a_col_gives_b: assert property (p_col_gives_b)
        else $error("column after data did not select format b");
    a_row_gives_a: assert property (p_row_gives_a)
        else $error("row after data did not select format a");
    a_c_sticks: assert property (p_c_sticks)
        else $error("format c left within a transmission");
    a_idle_resets: assert property (p_idle_resets)
        else $error("decoder not back to format a between frames");
    a_always_ready: assert property (p_always_ready)
        else $error("device refused a byte");
    a_valid_pulse: assert property (p_valid_pulse)
        else $error("byte valid stood more than one cycle");
    a_fmt_cause: assert property (p_fmt_cause)
        else $error("format changed without a byte");
endmodule // osd_link_checker
`default_nettype wire

// *** tb/osd_memory_write_decoder_tb.sv ***
`default_nettype none
module osd_memory_write_decoder_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic frame_tick = 1'b0;
    logic [3:0] rd_row = 4'h0;
    logic [4:0] rd_col = 5'h00;
    logic rd_attr = 1'b0;
    logic [3:0] scan_row = 4'h0;
    logic in_window = 1'b0;
    logic in_shadow = 1'b0;
    logic [7:0] rd_data;
    logic [7:0] shadow_m;
    logic [7:0] shadow_n;
    logic [1:0] fmt;
    logic [3:0] mem_row;
    logic pix_int, win_on, win_black, hold = 1'b0;
    logic [31:0] rq;
    logic re;
    logic [7:0] mem [2][16][32];
    logic [9:0] cells [$];
    int miscompares = 0;
    int comparisons = 0;
    // ************************************************************
    // both ends joined by the link
    // ************************************************************
    osd_link_if link ();
    osd_host_end u_osd_host_end (.clk_sys(clk_sys), .rst_n(rst_n),
        .clk_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(link));
    osd_device_end u_osd_device_end (.clk_sys(clk_sys), .rst_n(rst_n),
        .clk_en(1'b1), .link(link), .frame_tick(frame_tick),
        .rd_row(rd_row), .rd_col(rd_col), .rd_attr(rd_attr),
        .scan_row(scan_row), .in_window(in_window), .in_shadow(in_shadow),
        .rd_data(rd_data), .pix_fg(), .pix_bg(), .pix_blank(),
        .mem_col(), .mem_row(mem_row), .pix_int(pix_int), .win_on(win_on),
        .win_black(win_black),
        .shadow_m(shadow_m), .shadow_n(shadow_n), .fmt(fmt));
    osd_link_checker u_osd_link_checker (.clk_sys(clk_sys), .rst_n(rst_n),
        .data(link.data), .valid(link.valid), .ready(link.ready),
        .frame(link.frame), .fmt(fmt));
    // clock
    always #20 clk_sys = ~clk_sys;
    // random video side so the display path is not left idle
    always @(posedge clk_sys) begin
        frame_tick <= ($urandom % 50) == 0;
        if (!hold) begin
            scan_row <= 4'($urandom);
            in_window <= 1'($urandom);
            in_shadow <= 1'($urandom);
        end
    end
    task automatic report_and_stop();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen,
            input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // one apb transfer; an idle cycle after keeps psel single-driven
    task automatic apb(input logic wr, input logic [11:0] a,
            input logic [31:0] d, output logic [31:0] q, output logic e);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1 && n < 100) begin
            n++;
            @(posedge clk_sys);
        end
        if (n == 100) miscompares++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    function automatic logic [7:0] rowb(input logic a, input logic [3:0] r);
        return {2'h2, a, 1'b0, r};
    endfunction
    function automatic logic [7:0] colb(input logic c, input logic [4:0] k);
        return {1'b0, c, 1'b0, k};
    endfunction
    // screen row to memory row from the tall bits written so far
    function automatic logic [3:0] tall_row(input logic [3:0] s);
        logic [4:0] top;
        top = 5'h00;
        tall_row = 4'h0;
        for (int i = 0; i < 15; i++) begin
            if (top <= {1'b0, s}) begin
                tall_row = 4'(i);
            end
            top = top + ((mem[1][i][30][osd_pkg::ROW_TALL_BIT] === 1'b1) ?
                5'h02 : 5'h01);
        end
    endfunction
    task automatic tx(input logic [7:0] b);
        apb(1'b1, 12'h000, {24'h0, b}, rq, re);
    endtask
    task automatic fr(input logic on);
        apb(1'b1, 12'h004, {31'h0, on}, rq, re);
    endtask
    // filler and unimplemented places keep nothing
    task automatic note(input logic a, input logic [3:0] r,
            input logic [4:0] k, input logic [7:0] b);
        if (r < osd_pkg::NUM_ROWS ?
                k < (a ? osd_pkg::LAST_COL : osd_pkg::NUM_COLS) :
                a && k < osd_pkg::NUM_CTRL_COLS) begin
            mem[a][r][k] = b;
            cells.push_back({a, r, k});
        end
    endtask
    task automatic wr_a(input logic a, input logic [3:0] r,
            input logic [4:0] k, input logic [7:0] b);
        tx(rowb(a, r));
        tx(colb(1'b0, k));
        tx(b);
        note(a, r, k, b);
    endtask
    task automatic burst_c(input logic a, input logic [3:0] r,
            input logic [4:0] k, input int n);
        logic [8:0] p;
        logic [7:0] b;
        p = {r, k};
        tx(rowb(a, r));
        tx(colb(1'b1, k));
        repeat (n) begin
            b = 8'($urandom);
            tx(b);
            note(a, p[8:5], p[4:0], b);
            p++;
        end
    endtask
    task automatic look(input logic a, input logic [3:0] r,
            input logic [4:0] k, input logic [7:0] e);
        rd_attr <= a;
        rd_row <= r;
        rd_col <= k;
        repeat (3) @(posedge clk_sys);
        check("rd_data", {24'h0, rd_data}, {24'h0, e});
    endtask
    task automatic see_fmt(input osd_pkg::fmt_t e);
        repeat (3) @(posedge clk_sys);
        check("fmt", {30'h0, fmt}, {30'h0, e});
    endtask
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        logic [3:0] r;
        logic [4:0] k;
        logic [7:0] b;
        void'($urandom(32'hd3de79cb));
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        look(1'b1, osd_pkg::CTRL_ROW, osd_pkg::WIN1_CTRL_COL, 8'h02);
        look(1'b1, 4'h3, osd_pkg::ROW_ATTR_COL, 8'h00);
        apb(1'b0, 12'h00c, 32'h0, rq, re);
        check("pslverr", {31'h0, re}, 32'h1);
        fr(1'b1);
        for (int i = 0; i < 10; i++) begin
            wr_a(1'(i), 4'($urandom % 15), 5'($urandom), 8'($urandom));
        end
        wr_a(1'b1, 4'h2, osd_pkg::ROW_ATTR_COL, 8'h07);
        wr_a(1'b1, osd_pkg::CTRL_ROW, osd_pkg::WIN1_CTRL_COL, 8'h05);
        wr_a(1'b1, osd_pkg::CTRL_ROW, osd_pkg::SHADOW_W_COL, 8'h3c);
        wr_a(1'b1, osd_pkg::CTRL_ROW, osd_pkg::SHADOW_H_COL, 8'hc3);
        repeat (2) @(posedge clk_sys);
        check("shadow_m", {24'h0, shadow_m}, 32'h3c);
        check("shadow_n", {24'h0, shadow_n}, 32'hc3);
        // freeze the video side on one screen row
        hold <= 1'b1;
        @(posedge clk_sys);
        scan_row <= 4'h5;
        in_window <= 1'b1;
        in_shadow <= 1'b1;
        repeat (3) @(posedge clk_sys);
        check("mem_row", {28'h0, mem_row}, {28'h0, tall_row(4'h5)});
        check("win_on", {31'h0, win_on}, 32'h1);
        check("pix_int", {31'h0, pix_int}, 32'h0);
        check("win_black", {31'h0, win_black}, 32'h1);
        hold <= 1'b0;
        r = 4'($urandom % 15);
        tx(rowb(1'b0, r));
        for (int i = 0; i < 4; i++) begin
            k = 5'($urandom % 30);
            b = 8'($urandom);
            tx(colb(1'b0, k));
            tx(b);
            note(1'b0, r, k, b);
        end
        see_fmt(osd_pkg::FMT_B);
        wr_a(1'b0, 4'h2, 5'h03, 8'h5a);
        see_fmt(osd_pkg::FMT_A);
        burst_c(1'b0, 4'hd, 5'h1c, 6);
        see_fmt(osd_pkg::FMT_C);
        fr(1'b0);
        see_fmt(osd_pkg::FMT_A);
        // bytes outside a transmission must not land
        tx(rowb(1'b0, 4'h2));
        tx(colb(1'b0, 5'h03));
        tx(8'ha5);
        fr(1'b1);
        burst_c(1'b1, 4'h4, 5'h1d, 4);
        fr(1'b0);
        fr(1'b1);
        burst_c(1'b0, 4'he, 5'h1e, 3);
        fr(1'b0);
        foreach (cells[j]) begin
            look(cells[j][9], cells[j][8:5], cells[j][4:0],
                mem[cells[j][9]][cells[j][8:5]][cells[j][4:0]]);
        end
        report_and_stop();
    end
    // watchdog far beyond the few hundred cycles the run needs
    initial begin
        repeat (20000) @(posedge clk_sys);
        miscompares++;
        report_and_stop();
    end
endmodule // osd_memory_write_decoder_tb
`default_nettype wire
